// ===== sim/lbra_bus_model.sv
`timescale 1ns/100ps
// external bus controller: answers each ext_req after dly idle cycles
module lbra_bus_model
    import lbra_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [3:0]  dly,
    input  wire logic        fault,
    input  wire logic        ext_req,
    input  lbra_req_t        ext_xfer,
    output logic             ext_done,
    output logic             ext_err,
    output logic      [31:0] ext_rdata,
    output logic      [7:0]  n_req
);
    logic [3:0] cnt_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg   <= 4'h0;
            ext_done  <= 1'b0;
            ext_err   <= 1'b0;
            ext_rdata <= 32'h0;
            n_req     <= 8'h00;
        end else begin
            ext_done  <= 1'b0;
            ext_err   <= 1'b0;
            // read data only holds in the done cycle
            ext_rdata <= ~ext_rdata;
            cnt_reg   <= (cnt_reg > 4'h1) ? cnt_reg - 4'h1 : 4'h0;
            if (ext_req) begin
                n_req   <= n_req + 8'h01;
                cnt_reg <= dly;
            end
            if ((ext_req && dly == 4'h0) || cnt_reg == 4'h1) begin
                ext_done  <= 1'b1;
                ext_err   <= fault;
                ext_rdata <= ~ext_xfer.addr;
            end
        end
    end
endmodule

// ===== sim/test_lbra_top.sv
`timescale 1ns/100ps
module test_lbra_top;
    import lbra_pkg::*;
    localparam logic [31:0] S0 = 32'h2000_4000;
    localparam logic [31:0] S1 = 32'h3001_0000;
    logic        clock = 0, rst_n = 0, ctl_wr = 0, cpu_req = 0, cpu_super = 0, cpu_ifetch = 0;
    logic        dbg_ref = 0, dma_req = 0, cpu_ready, cpu_ack, cpu_err, cache_discard, cache_alloc_ok;
    logic        ext_req, ext_done, dma_ready, dma_ack, dma_err, err, disc, alloc;
    logic        ext_err, fault = 0, rdy;
    logic [11:0] ctl_sel = 12'h000;
    logic [31:0] ctl_wdata = 32'h0, ctl_rdata, cpu_rdata, dma_rdata, ext_rdata, rd;
    lbra_req_t   cpu_xfer = '0, dma_xfer = '0, ext_xfer;
    lbra_attr_t  dflt_attr = 3'b100, ext_attr;
    logic [3:0]  dly = 4'h0;
    logic [7:0]  n_req, n0;
    logic [31:0] t_rgn [5] = '{32'h4000_8060, 32'h4000_8060, 32'h4000_a060, 32'h4000_a060, 32'h4000_4060};
    int          n_errors = 0, checks = 0, lat;

    always #50 clock = ~clock;

    lbra_top lbra_top_inst (.clock, .rst_n, .ctl_wr, .ctl_sel, .ctl_wdata, .ctl_rdata, .cpu_req, .cpu_xfer,
        .cpu_super, .cpu_ifetch, .dbg_ref, .cpu_ready, .cpu_ack, .cpu_err, .cpu_rdata, .cache_discard,
        .cache_alloc_ok, .dflt_attr, .ext_req, .ext_xfer, .ext_attr, .ext_done, .ext_err, .ext_rdata,
        .dma_req, .dma_xfer, .dma_ready, .dma_ack, .dma_err, .dma_rdata);
    lbra_bus_model lbra_bus_model_inst (.clock, .rst_n, .dly, .fault, .ext_req, .ext_xfer, .ext_done, .ext_err,
        .ext_rdata, .n_req);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wreg(input logic [11:0] sel, input logic [31:0] d);
        @(negedge clock);
        ctl_wr = 1'b1;
        ctl_sel = sel;
        ctl_wdata = d;
        @(negedge clock);
        ctl_wr = 1'b0;
    endtask

    task automatic rreg(input logic [11:0] sel);
        @(negedge clock);
        ctl_sel = sel;
        @(negedge clock);
        rd = ctl_rdata;
    endtask

    // one local-bus transfer; lat counts cycles from the taking edge to cpu_ack
    task automatic acc(input logic wr, input logic [1:0] sz, input logic [31:0] a, input logic [31:0] d,
                       input logic sup, input logic ifx);
        @(negedge clock);
        cpu_req = 1'b1;
        cpu_xfer = '{wr, sz, a, d};
        cpu_super = sup;
        cpu_ifetch = ifx;
        while (cpu_ready !== 1'b1) @(negedge clock);
        @(negedge clock);
        cpu_req = 1'b0;
        rdy = cpu_ready;
        lat = 1;
        while (cpu_ack !== 1'b1 && lat < 20) begin
            @(negedge clock);
            lat++;
        end
        chk(cpu_ack, 1'b1);
        rd = cpu_rdata;
        err = cpu_err;
        disc = cache_discard;
        alloc = cache_alloc_ok;
    endtask

    task automatic dacc(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(negedge clock);
        dma_req = 1'b1;
        dma_xfer = '{wr, SZ_LONG, a, d};
        @(negedge clock);
        dma_req = 1'b0;
        chk(dma_ack, 1'b1);
        rd = dma_rdata;
        err = dma_err;
    endtask

    task automatic wrap_up;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // the whole sequence needs well under 2000 cycles
    initial begin
        #200000;
        n_errors++;
        wrap_up;
    end

    initial begin
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        rreg(CSEL_RGN0);
        chk(rd, 32'h0);
        rreg(CSEL_BAR0);
        chk(rd & 32'h1, 32'h0);
        wreg(CSEL_BAR0, S0 | 32'h1);
        wreg(CSEL_BAR1, S1 | 32'h1);
        rreg(CSEL_BAR0);
        chk(rd, S0 | 32'h1);
        acc(1'b1, SZ_LONG, S0, 32'h1122_3344, 1'b0, 1'b0);
        chk(lat, 1);
        acc(1'b1, SZ_BYTE, S0 + 32'h1, 32'h00aa_0000, 1'b0, 1'b0);
        acc(1'b1, SZ_WORD, S0 + 32'h2, 32'h0000_beef, 1'b0, 1'b0);
        acc(1'b0, SZ_LONG, S0, 32'h0, 1'b0, 1'b1);
        chk(rd, 32'h11aa_beef);
        chk({disc, alloc, lat[3:0]}, 6'h21);
        acc(1'b1, SZ_LONG, S0 + 32'h7ffc, 32'h5a5a_0f0f, 1'b0, 1'b0);
        acc(1'b0, SZ_LONG, S0 + 32'h7ffc, 32'h0, 1'b0, 1'b0);
        chk(rd, 32'h5a5a_0f0f);
        chk(n_req, 8'h00);
        acc(1'b0, SZ_LONG, S0 + 32'h8000, 32'h0, 1'b0, 1'b0);
        chk({lat[3:0], n_req}, 12'h301);
        chk(rd, ~(S0 + 32'h8000));
        chk(ext_attr, dflt_attr);
        dbg_ref = 1'b1;
        acc(1'b0, SZ_LONG, S0, 32'h0, 1'b1, 1'b0);
        dbg_ref = 1'b0;
        chk(rd, 32'h11aa_beef);
        dacc(1'b0, S0, 32'h0);
        chk(err, 1'b1);
        dacc(1'b1, S1 + 32'h8000, 32'hc0de_1234);
        acc(1'b0, SZ_LONG, S1 + 32'h8000, 32'h0, 1'b0, 1'b0);
        chk(rd, 32'hc0de_1234);
        dacc(1'b0, S1 + 32'h8000, 32'h0);
        chk(rd, 32'hc0de_1234);
        for (int i = 0; i < 2; i++) begin
            @(negedge clock);
            cpu_req = 1'b1;
            cpu_xfer = '{1'b0, SZ_LONG, S1, 32'h0};
            dma_req = 1'b1;
            dma_xfer = '{1'b0, SZ_LONG, S1 + (i ? 32'h4 : 32'h8000), 32'h0};
            #1 chk(dma_ready, !i);
            @(negedge clock);
            cpu_req = 1'b0;
            chk({cpu_ack, dma_ack}, {1'b1, i == 0});
            if (i) @(negedge clock);
            dma_req = 1'b0;
            chk(dma_ack, 1'b1);
        end
        wreg(CSEL_RGN0, 32'h4000_c020);
        rreg(CSEL_RGN0);
        chk(rd, 32'h4000_c020);
        acc(1'b0, SZ_LONG, 32'h4000_0010, 32'h0, 1'b0, 1'b1);
        chk({ext_attr, alloc, disc}, 5'b01010);
        acc(1'b0, SZ_LONG, 32'h4100_0010, 32'h0, 1'b0, 1'b0);
        chk(ext_attr, dflt_attr);
        wreg(CSEL_RGN0, 32'h4001_c020);
        acc(1'b0, SZ_LONG, 32'h4100_0010, 32'h0, 1'b0, 1'b0);
        chk(ext_attr, 3'b010);
        dly = 4'h3;
        acc(1'b1, SZ_LONG, 32'h4000_0040, 32'h0, 1'b0, 1'b0);
        chk({rdy, lat[3:0]}, 5'h11);
        repeat (8) @(negedge clock);
        for (int i = 0; i < 5; i++) begin
            wreg(CSEL_RGN0, t_rgn[i]);
            acc(1'b0, SZ_LONG, 32'h4000_0010, 32'h0, i[0], 1'b0);
            chk(ext_attr, (i == 0 || i == 3) ? 3'b110 : dflt_attr);
        end
        wreg(CSEL_RGN0, 32'h4000_c000);
        acc(1'b1, SZ_LONG, 32'h4000_0010, 32'h0, 1'b0, 1'b0);
        chk({rdy, lat[3:0]}, 5'h06);
        fault = 1'b1;
        acc(1'b0, SZ_LONG, 32'h4100_0010, 32'h0, 1'b0, 1'b0);
        fault = 1'b0;
        chk({err, rdy}, 2'b10);
        wreg(CSEL_RGN1, 32'h00ff_c004);
        acc(1'b0, SZ_LONG, 32'h4000_0010, 32'h0, 1'b0, 1'b0);
        chk(ext_attr, 3'b000);
        n0 = n_req;
        acc(1'b1, SZ_LONG, 32'h5000_0000, 32'h0, 1'b0, 1'b0);
        chk({err, lat[3:0], n_req}, {1'b1, 4'h1, n0});
        acc(1'b0, SZ_LONG, 32'h5000_0000, 32'h0, 1'b0, 1'b0);
        chk({err, ext_attr}, 4'b0001);
        acc(1'b1, SZ_LONG, S0, 32'h7777_0000, 1'b0, 1'b0);
        chk({err, lat[3:0]}, 5'h01);
        dly = 4'h0;
        @(negedge clock);
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        rreg(CSEL_BAR0);
        chk(rd, S0);
        rreg(CSEL_RGN1);
        chk(rd, 32'h0);
        acc(1'b0, SZ_LONG, S0, 32'h0, 1'b0, 1'b0);
        chk(lat, 3);
        wrap_up;
    end
endmodule

// ===== verilog/lbra_pkg.sv
package lbra_pkg;
    // control register select codes
    localparam logic [11:0] CSEL_RGN0 = 12'h004;
    localparam logic [11:0] CSEL_RGN1 = 12'h005;
    localparam logic [11:0] CSEL_BAR0 = 12'hc04;
    localparam logic [11:0] CSEL_BAR1 = 12'hc05;

    // region attribute register fields
    localparam int RGN_BASE_HI  = 31;
    localparam int RGN_BASE_LO  = 24;
    localparam int RGN_MASK_HI  = 23;
    localparam int RGN_MASK_LO  = 16;
    localparam int RGN_EN       = 15;
    localparam int RGN_PRIV_ANY = 14;
    localparam int RGN_PRIV_SUP = 13;
    localparam int RGN_CI       = 6;
    localparam int RGN_BUFW     = 5;
    localparam int RGN_WP       = 2;
    localparam logic [31:0] RGN_RMASK = 32'hffff_e064;
    localparam logic [31:0] RGN_RESET = 32'h0000_0000;

    // sram base register fields
    localparam int BAR_V  = 0;
    localparam int BAR_WP = 8;
    localparam logic [31:0] BAR_BA_MASK = 32'hffff_c000;
    localparam logic [31:0] BAR0_RMASK  = 32'hffff_c13f;
    localparam logic [31:0] BAR1_RMASK  = 32'hffff_cf3f;

    // access sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;

    // sram array shape
    localparam int ARR_LINES      = 2048;
    localparam int ARR_LINE_BYTES = 16;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXT  = 1'b1
    } lbra_st_t;

    typedef struct packed {
        logic        wr;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } lbra_req_t;

    typedef struct packed {
        logic ci;
        logic bw;
        logic wp;
    } lbra_attr_t;

    typedef struct packed {
        logic [1:0][31:0] rgn;
        logic [1:0]       bar_v;
        lbra_st_t         st;
        logic             pend_fetch;
        logic             cpu_ack;
        logic             cpu_err;
        logic             cache_discard;
        logic             alloc_ok;
        logic [31:0]      cpu_rdata;
        logic             ext_req;
        lbra_req_t        ext_xfer;
        lbra_attr_t       ext_attr;
        logic             dma_ack;
        logic             dma_err;
        logic [31:0]      dma_rdata;
        logic [31:0]      ctl_rdata;
    } lbra_state_t;

    localparam lbra_state_t STATE_RESET = '0;
endpackage

// ===== verilog/lbra_top.sv
// What this block does
// - compare address bits 31:24 with each region's 8-bit base byte
// - on a region match take caching, buffering and protection from that region
// - set mask bits exclude their bit positions from the base comparison
// - region enable bit, 1 enables matching; reset clears it
// - privilege select 00 user only, 01 supervisor only, 1x any mode
// - unbuffered writes are acknowledged only after the external cycle completes
// - buffered writes are acknowledged at once and left to the bus controller
// - write-protected writes end with an access error; reads still allowed
// - each sram answers processor accesses in one local-bus cycle
// - sram base is programmable on any 16K boundary in 4 GB
// - sram hit on instruction fetch returns sram data, cache result discarded
// - data from the sram is never allocated into the cache
// - sram serves both processor and debug memory references
// - the 32K sram cannot be reached by dma
// - the 64K sram is reachable by dma and processor
// - first sram is one array of 2048 lines of 16 bytes
// - second sram is two 2048-line banks, dma and cpu in parallel on different banks
// - byte, word and longword accesses are supported
// - region registers only apply to references outside the srams
// - with no region match the default attributes from cache control apply
// - reset clears each sram valid bit only, other base bits kept
`timescale 1ns/100ps
module lbra_top
    import lbra_pkg::*;
#(
    parameter int LINES      = ARR_LINES,
    parameter int LINE_BYTES = ARR_LINE_BYTES
)(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        ctl_wr,
    input  wire logic [11:0] ctl_sel,
    input  wire logic [31:0] ctl_wdata,
    output logic      [31:0] ctl_rdata,
    input  wire logic        cpu_req,
    input  lbra_req_t        cpu_xfer,
    input  wire logic        cpu_super,
    input  wire logic        cpu_ifetch,
    input  wire logic        dbg_ref,
    output logic             cpu_ready,
    output logic             cpu_ack,
    output logic             cpu_err,
    output logic      [31:0] cpu_rdata,
    output logic             cache_discard,
    output logic             cache_alloc_ok,
    input  lbra_attr_t       dflt_attr,
    output logic             ext_req,
    output lbra_req_t        ext_xfer,
    output lbra_attr_t       ext_attr,
    input  wire logic        ext_done,
    input  wire logic        ext_err,
    input  wire logic [31:0] ext_rdata,
    input  wire logic        dma_req,
    input  lbra_req_t        dma_xfer,
    output logic             dma_ready,
    output logic             dma_ack,
    output logic             dma_err,
    output logic      [31:0] dma_rdata
);
    localparam int WPA       = LINES * LINE_BYTES / 4;
    localparam int AW        = $clog2(WPA);
    localparam int ARR_BYTES = LINES * LINE_BYTES;
    localparam logic [31:0] SIZE0 = 32'(ARR_BYTES);
    localparam logic [31:0] SIZE1 = 32'(2 * ARR_BYTES);

    if (LINE_BYTES < 4 || (LINE_BYTES & (LINE_BYTES - 1)) != 0 || (LINES & (LINES - 1)) != 0
        || ARR_BYTES < 16384) begin : g_chk
        $error("lbra_top: unsupported sram shape");
    end

    lbra_state_t s_reg;
    lbra_state_t s_next;

    logic [31:0] mem0 [WPA];
    logic [31:0] mem1 [2][WPA];
    logic [1:0][31:0] bar_raw;

    logic        sup;
    logic [1:0]  rh;
    lbra_attr_t  eff;
    logic [31:0] off0;
    logic [31:0] off1;
    logic [31:0] doff;
    logic        hit0;
    logic        hit1;
    logic        shit;
    logic        dhit;
    logic        bank1;
    logic        dbank;
    logic [AW-1:0] idx0;
    logic [AW-1:0] idx1;
    logic [AW-1:0] didx;
    logic        take;
    logic        werr;
    logic        dgo;
    logic [3:0]  cmask;
    logic [3:0]  dmask;

    function automatic logic rgn_hit(logic [31:0] a, logic [31:0] addr, logic s);
        logic bm;
        logic pm;
        bm = ((addr[RGN_BASE_HI:RGN_BASE_LO] ^ a[RGN_BASE_HI:RGN_BASE_LO])
              & ~a[RGN_MASK_HI:RGN_MASK_LO]) == 8'h00;
        pm = a[RGN_PRIV_ANY] | (a[RGN_PRIV_SUP] == s);
        return a[RGN_EN] & bm & pm;
    endfunction

    function automatic lbra_attr_t rgn_attr(logic [31:0] a);
        lbra_attr_t t;
        t.ci = a[RGN_CI];
        t.bw = a[RGN_BUFW];
        t.wp = a[RGN_WP];
        return t;
    endfunction

    // big-endian lanes: byte at offset 0 sits on bits 31:24
    function automatic logic [3:0] lanes(logic [1:0] size, logic [1:0] a);
        logic [3:0] m;
        case (size)
            SZ_BYTE: m = 4'h8 >> a;
            SZ_WORD: m = a[1] ? 4'h3 : 4'hc;
            default: m = 4'hf;
        endcase
        return m;
    endfunction

    function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] m);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (m[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // decode: debug references count as supervisor
    always_comb begin
        sup   = cpu_super | dbg_ref;
        rh[0] = rgn_hit(s_reg.rgn[0], cpu_xfer.addr, sup);
        rh[1] = rgn_hit(s_reg.rgn[1], cpu_xfer.addr, sup);
        if (rh[0]) begin
            eff = rgn_attr(s_reg.rgn[0]);
        end else if (rh[1]) begin
            eff = rgn_attr(s_reg.rgn[1]);
        end else begin
            eff = dflt_attr;
        end
        off0  = cpu_xfer.addr - (bar_raw[0] & BAR_BA_MASK);
        off1  = cpu_xfer.addr - (bar_raw[1] & BAR_BA_MASK);
        doff  = dma_xfer.addr - (bar_raw[1] & BAR_BA_MASK);
        hit0  = s_reg.bar_v[0] && (off0 < SIZE0);
        hit1  = s_reg.bar_v[1] && (off1 < SIZE1) && !hit0;
        shit  = hit0 | hit1;
        dhit  = s_reg.bar_v[1] && (doff < SIZE1);
        idx0  = off0[AW+1:2];
        idx1  = off1[AW+1:2];
        bank1 = off1[AW+2];
        didx  = doff[AW+1:2];
        dbank = doff[AW+2];
        cpu_ready = (s_reg.st == ST_IDLE);
        take  = cpu_req && cpu_ready;
        // region attributes only matter when no sram claims the reference
        werr  = cpu_xfer.wr && (shit ? (hit0 ? bar_raw[0][BAR_WP] : bar_raw[1][BAR_WP]) : eff.wp);
        dma_ready = !(take && hit1 && dhit && (dbank == bank1));
        dgo   = dma_req && dma_ready;
        cmask = lanes(cpu_xfer.size, cpu_xfer.addr[1:0]);
        dmask = lanes(dma_xfer.size, dma_xfer.addr[1:0]);
    end

    // sram arrays and base fields carry no reset
    always_ff @(posedge clock) begin
        if (take && hit0 && cpu_xfer.wr && !werr) begin
            mem0[idx0] <= merge(mem0[idx0], cpu_xfer.wdata, cmask);
        end
        for (int b = 0; b < 2; b++) begin
            if (take && hit1 && cpu_xfer.wr && !werr && bank1 == 1'(b)) begin
                mem1[b][idx1] <= merge(mem1[b][idx1], cpu_xfer.wdata, cmask);
            end else if (dgo && dhit && dma_xfer.wr && dbank == 1'(b)) begin
                mem1[b][didx] <= merge(mem1[b][didx], dma_xfer.wdata, dmask);
            end
        end
        if (ctl_wr && ctl_sel == CSEL_BAR0) begin
            bar_raw[0] <= ctl_wdata & BAR0_RMASK;
        end
        if (ctl_wr && ctl_sel == CSEL_BAR1) begin
            bar_raw[1] <= ctl_wdata & BAR1_RMASK;
        end
    end

    always_comb begin
        s_next = s_reg;
        s_next.cpu_ack       = 1'b0;
        s_next.cpu_err       = 1'b0;
        s_next.cache_discard = 1'b0;
        s_next.alloc_ok      = 1'b0;
        s_next.ext_req       = 1'b0;
        s_next.dma_ack       = 1'b0;
        s_next.dma_err       = 1'b0;
        if (ctl_wr) begin
            case (ctl_sel)
                CSEL_RGN0: s_next.rgn[0] = ctl_wdata & RGN_RMASK;
                CSEL_RGN1: s_next.rgn[1] = ctl_wdata & RGN_RMASK;
                CSEL_BAR0: s_next.bar_v[0] = ctl_wdata[BAR_V];
                CSEL_BAR1: s_next.bar_v[1] = ctl_wdata[BAR_V];
                default:   s_next.rgn = s_reg.rgn;
            endcase
        end
        case (ctl_sel)
            CSEL_RGN0: s_next.ctl_rdata = s_reg.rgn[0];
            CSEL_RGN1: s_next.ctl_rdata = s_reg.rgn[1];
            CSEL_BAR0: s_next.ctl_rdata = {bar_raw[0][31:1], s_reg.bar_v[0]};
            CSEL_BAR1: s_next.ctl_rdata = {bar_raw[1][31:1], s_reg.bar_v[1]};
            default:   s_next.ctl_rdata = 32'h0000_0000;
        endcase
        case (s_reg.st)
            ST_IDLE: begin
                if (take) begin
                    if (werr) begin
                        s_next.cpu_ack = 1'b1;
                        s_next.cpu_err = 1'b1;
                    end else if (shit) begin
                        s_next.cpu_ack       = 1'b1;
                        s_next.cpu_rdata     = hit0 ? mem0[idx0] : mem1[bank1][idx1];
                        s_next.cache_discard = cpu_ifetch;
                    end else begin
                        s_next.ext_req  = 1'b1;
                        s_next.ext_xfer = cpu_xfer;
                        s_next.ext_attr = eff;
                        if (cpu_xfer.wr && eff.bw) begin
                            s_next.cpu_ack = 1'b1;
                        end else begin
                            s_next.st         = ST_EXT;
                            s_next.pend_fetch = cpu_ifetch;
                        end
                    end
                end
            end
            ST_EXT: begin
                if (ext_done) begin
                    s_next.cpu_ack   = 1'b1;
                    s_next.cpu_err   = ext_err;
                    s_next.cpu_rdata = ext_rdata;
                    s_next.alloc_ok  = s_reg.pend_fetch && !s_reg.ext_attr.ci && !s_reg.ext_xfer.wr;
                    s_next.st        = ST_IDLE;
                end
            end
            default: s_next.st = ST_IDLE;
        endcase
        if (dgo) begin
            s_next.dma_ack = 1'b1;
            s_next.dma_err = !dhit;
            if (dhit) begin
                s_next.dma_rdata = mem1[dbank][didx];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= STATE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign ctl_rdata      = s_reg.ctl_rdata;
    assign cpu_ack        = s_reg.cpu_ack;
    assign cpu_err        = s_reg.cpu_err;
    assign cpu_rdata      = s_reg.cpu_rdata;
    assign cache_discard  = s_reg.cache_discard;
    assign cache_alloc_ok = s_reg.alloc_ok;
    assign ext_req        = s_reg.ext_req;
    assign ext_xfer       = s_reg.ext_xfer;
    assign ext_attr       = s_reg.ext_attr;
    assign dma_ack        = s_reg.dma_ack;
    assign dma_err        = s_reg.dma_err;
    assign dma_rdata      = s_reg.dma_rdata;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_dflt;
        take && !shit && !rh[0] && !rh[1] && !cpu_xfer.wr |=> ext_req && ext_attr == $past(dflt_attr);
    endproperty
    a_dflt: assert property (p_dflt) else $error("default attributes not applied");
    property p_rgn0;
        take && !shit && rh[0] && !cpu_xfer.wr |=> ext_req && ext_attr == rgn_attr($past(s_reg.rgn[0]));
    endproperty
    a_rgn0: assert property (p_rgn0) else $error("region 0 attributes not applied");
    property p_en_off;
        ctl_wr && ctl_sel == CSEL_RGN0 && !ctl_wdata[RGN_EN] |=> !rh[0];
    endproperty
    a_en_off: assert property (p_en_off) else $error("disabled region still matches");
    property p_wp;
        take && werr |=> cpu_ack && cpu_err && !ext_req;
    endproperty
    a_wp: assert property (p_wp) else $error("protected write not refused");
    property p_unbuf;
        take && !shit && !werr && cpu_xfer.wr && !eff.bw ##1 (!ext_done)[*2] |=> !cpu_ack;
    endproperty
    a_unbuf: assert property (p_unbuf) else $error("unbuffered write acked early");
    property p_buf;
        take && !shit && !werr && cpu_xfer.wr && eff.bw |=> cpu_ack && !cpu_err && ext_req && cpu_ready;
    endproperty
    a_buf: assert property (p_buf) else $error("buffered write not acked at once");
    property p_one;
        take && shit && !werr |=> cpu_ack && !ext_req && !cache_alloc_ok;
    endproperty
    a_one: assert property (p_one) else $error("sram access not single cycle");
    property p_fetch;
        take && shit && !werr && cpu_ifetch |=> cache_discard;
    endproperty
    a_fetch: assert property (p_fetch) else $error("cache result not discarded");
    property p_dma0;
        dgo && !dhit |=> dma_ack && dma_err;
    endproperty
    a_dma0: assert property (p_dma0) else $error("dma reached outside shared sram");
    property p_dma1;
        dgo && dhit |=> dma_ack && !dma_err;
    endproperty
    a_dma1: assert property (p_dma1) else $error("dma to shared sram refused");
    property p_par;
        take && hit1 && dma_req && dhit && dbank != bank1 |-> dma_ready;
    endproperty
    a_par: assert property (p_par) else $error("dma stalled on other bank");

    c_sram: cover property (take && shit ##1 cpu_ack);
    c_ext: cover property (take && !shit && !cpu_xfer.wr ##[1:20] cpu_ack);
    c_dual: cover property (take && hit1 && dgo && dhit);
endmodule
